// *** rtl/edrc_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] strobe release floats data after later turnoff
// [R2] oe or we release floats, earliest wins
// [R3] outputs float at earliest of both paths
// [R4] read hold met before any we pulse
// [R5] cas low before ras, held after fall
// [R6] cas high after precharge before refresh
// [R7] self refresh holds ras low long enough
// [R8] precharge after self refresh exit
// [R9] cas may rise with ras on exit
// [R10] self refresh only on low-power variant
// [R11] unselected lane ignored in byte cycles
// [R12] any read/write mix within one page
// [R13] each byte lane strobed independently
// [R14] distributed refresh combines with self refresh
// [R15] burst refresh around self refresh if used
// [R16] short self refresh pulse is one refresh
// [R17] all rows refreshed within the period
// [R18] refresh: data floated, we/oe idle
// [R19] refresh row from device counter
module edrc_ctrl #(
  parameter bit LOW_POWER = 1'b1,
  parameter int REF_CYC_P = edrc_pkg::REF_CYC,
  parameter int RASS_CYC_P = edrc_pkg::RASS_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_be,
  input wire logic [2*edrc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [edrc_pkg::DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [edrc_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic self_refresh_req,
  output logic self_refresh_active,
  output logic row_strobe_n,
  output logic upper_byte_column_strobe_n,
  output logic lower_byte_column_strobe_n,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic [edrc_pkg::ADDR_W-1:0] mem_addr,
  output logic [edrc_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [edrc_pkg::DATA_W-1:0] dq_in
);
  import edrc_pkg::*;

  if (REF_CYC_P < 2 || REF_CYC_P > REF_CYC || RASS_CYC_P < 1 ||
      RASS_CYC_P >= (1 << TMR_W) || DATA_W != 16) begin : g_chk
    $error("edrc_ctrl: unsupported parameter values");
  end

  edrc_tmr_if #(.W(TMR_W)) tmr ();
  edrc_timer #(.W(TMR_W)) u_timer (.clk(clk), .srst(srst), .t(tmr));

  edrc_state_t state_q, state_d;
  logic ras_n_q, ras_n_d, upper_byte_column_strobe_n_n_q, upper_byte_column_strobe_n_n_d, lower_byte_column_strobe_n_n_q, lower_byte_column_strobe_n_n_d;
  logic we_n_q, we_n_d, oe_n_q, oe_n_d, dq_oe_n_q, dq_oe_n_d;
  logic [ADDR_W-1:0] addr_q, addr_d, row_q, row_d, col_q, col_d;
  logic [DATA_W-1:0] dq_out_q, dq_out_d, wdata_q, wdata_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic write_q, write_d, self_q, self_d;
  logic [1:0] be_q, be_d;
  logic rsp_valid_q, rsp_valid_d;
  logic ref_pend_q, ref_pend_d;
  logic [TMR_W-1:0] ref_cnt_q, ref_cnt_d;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q, dq_s3_q;
  logic go_col, ref_set, ref_clr, sr_want, same_row;

  // self refresh is refused outright on the standard variant
  assign sr_want = self_refresh_req && LOW_POWER; // see [R10]
  assign same_row = (req_addr[2*ADDR_W-1:ADDR_W] == row_q);

  always_comb begin
    state_d = state_q;
    ras_n_d = ras_n_q;
    upper_byte_column_strobe_n_n_d = upper_byte_column_strobe_n_n_q;
    lower_byte_column_strobe_n_n_d = lower_byte_column_strobe_n_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    dq_oe_n_d = dq_oe_n_q;
    addr_d = addr_q;
    dq_out_d = dq_out_q;
    row_d = row_q;
    col_d = col_q;
    wdata_d = wdata_q;
    write_d = write_q;
    be_d = be_q;
    self_d = self_q;
    rdata_d = rdata_q;
    rsp_valid_d = 1'b0;
    req_ready = 1'b0;
    tmr.load = 1'b0;
    tmr.value = '0;
    go_col = 1'b0;
    ref_clr = 1'b0;
    ref_set = (ref_cnt_q == '0);
    ref_cnt_d = ref_set ? TMR_W'(REF_CYC_P - 1) : ref_cnt_q - 1'b1;
    case (state_q)
      S_IDLE: begin
        if (ref_pend_q || sr_want) begin
          // address, we and oe left idle: the device counts rows itself
          upper_byte_column_strobe_n_n_d = 1'b0; // see [R5] [R19]
          lower_byte_column_strobe_n_n_d = 1'b0;
          self_d = !ref_pend_q;
          // distributed refresh only, so no burst is owed around self refresh
          ref_clr = ref_pend_q; // see [R14] [R15] [R17]
          tmr.load = 1'b1;
          tmr.value = TMR_W'(CSR_CYC);
          state_d = S_CBR_SET;
        end else begin
          req_ready = 1'b1;
          if (req_valid) begin
            row_d = req_addr[2*ADDR_W-1:ADDR_W];
            col_d = req_addr[ADDR_W-1:0];
            write_d = req_write;
            be_d = req_be;
            wdata_d = req_wdata;
            addr_d = req_addr[2*ADDR_W-1:ADDR_W];
            ras_n_d = 1'b0;
            tmr.load = 1'b1;
            tmr.value = TMR_W'(RCD_CYC);
            state_d = S_ROW;
          end
        end
      end
      S_ROW: begin
        go_col = tmr.expired;
      end
      S_COL: begin
        // wait for the resynchronised bus to settle before capture
        if (tmr.expired && (write_q || dq_s2_q == dq_s3_q)) begin
          upper_byte_column_strobe_n_n_d = 1'b1; // see [R1]
          lower_byte_column_strobe_n_n_d = 1'b1;
          oe_n_d = 1'b1; // see [R2] [R3] [R4]
          we_n_d = 1'b1;
          dq_oe_n_d = 1'b1;
          rsp_valid_d = !write_q;
          if (!write_q) begin
            rdata_d = dq_s3_q;
          end
          tmr.load = 1'b1;
          tmr.value = TMR_W'(CP_CYC);
          state_d = S_CEND;
        end
      end
      S_CEND: begin
        if (tmr.expired) begin
          if (same_row && !ref_pend_q && !sr_want) begin
            req_ready = 1'b1; // see [R12]
          end
          if (req_ready && req_valid) begin
            col_d = req_addr[ADDR_W-1:0];
            write_d = req_write;
            be_d = req_be;
            wdata_d = req_wdata;
            go_col = 1'b1;
          end else begin
            ras_n_d = 1'b1;
            tmr.load = 1'b1;
            tmr.value = TMR_W'(RP_CYC);
            state_d = S_PRE;
          end
        end
      end
      S_PRE: begin
        // cas stays high here, giving the column hold before refresh
        if (tmr.expired) begin
          state_d = S_IDLE; // see [R6]
        end
      end
      S_CBR_SET: begin
        if (tmr.expired) begin
          ras_n_d = 1'b0;
          tmr.load = 1'b1;
          tmr.value = self_q ? TMR_W'(RASS_CYC_P) : TMR_W'(RAS_CYC);
          state_d = S_CBR_HOLD;
        end
      end
      S_CBR_HOLD: begin
        // never leave self refresh early: a short pulse is one refresh
        if (tmr.expired && !(self_q && sr_want)) begin // see [R7] [R16]
          ras_n_d = 1'b1;
          upper_byte_column_strobe_n_n_d = 1'b1; // see [R9]
          lower_byte_column_strobe_n_n_d = 1'b1;
          self_d = 1'b0;
          tmr.load = 1'b1;
          tmr.value = self_q ? TMR_W'(RPS_CYC) : TMR_W'(RP_CYC); // see [R8]
          state_d = S_PRE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (go_col) begin
      addr_d = col_d;
      we_n_d = !write_d;
      oe_n_d = write_d;
      dq_out_d = wdata_d;
      dq_oe_n_d = !write_d;
      // unselected lane keeps its strobe high, but its bits still enter the settle compare and rsp_rdata
      upper_byte_column_strobe_n_n_d = !be_d[1]; // see [R11] [R13]
      lower_byte_column_strobe_n_n_d = !be_d[0];
      tmr.load = 1'b1;
      tmr.value = write_d ? TMR_W'(CAS_CYC) : TMR_W'(RD_CYC);
      state_d = S_COL;
    end
    // a new refresh tick wins over the clear
    ref_pend_d = ref_set || (ref_pend_q && !ref_clr);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= S_IDLE;
      ras_n_q <= 1'b1;
      upper_byte_column_strobe_n_n_q <= 1'b1;
      lower_byte_column_strobe_n_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      dq_oe_n_q <= 1'b1;
      addr_q <= '0;
      dq_out_q <= '0;
      row_q <= '0;
      col_q <= '0;
      wdata_q <= '0;
      write_q <= 1'b0;
      be_q <= '0;
      self_q <= 1'b0;
      rdata_q <= '0;
      rsp_valid_q <= 1'b0;
      ref_pend_q <= 1'b0;
      ref_cnt_q <= TMR_W'(REF_CYC_P - 1);
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dq_s3_q <= '0;
    end else begin
      state_q <= state_d;
      ras_n_q <= ras_n_d;
      upper_byte_column_strobe_n_n_q <= upper_byte_column_strobe_n_n_d;
      lower_byte_column_strobe_n_n_q <= lower_byte_column_strobe_n_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      dq_oe_n_q <= dq_oe_n_d;
      addr_q <= addr_d;
      dq_out_q <= dq_out_d;
      row_q <= row_d;
      col_q <= col_d;
      wdata_q <= wdata_d;
      write_q <= write_d;
      be_q <= be_d;
      self_q <= self_d;
      rdata_q <= rdata_d;
      rsp_valid_q <= rsp_valid_d;
      ref_pend_q <= ref_pend_d;
      ref_cnt_q <= ref_cnt_d;
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  assign row_strobe_n = ras_n_q;
  assign upper_byte_column_strobe_n = upper_byte_column_strobe_n_n_q;
  assign lower_byte_column_strobe_n = lower_byte_column_strobe_n_n_q;
  assign write_enable_n = we_n_q;
  assign output_enable_n = oe_n_q;
  assign mem_addr = addr_q;
  assign dq_out = dq_out_q;
  assign dq_oe_n = dq_oe_n_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rdata_q;
  assign self_refresh_active = self_q && (state_q == S_CBR_HOLD);

  // helper counters read only by the checks below
  logic [TMR_W:0] ras_lo_cnt_q, ras_hi_cnt_q, ref_gap_q;
  logic last_self_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      ras_lo_cnt_q <= '0;
      ras_hi_cnt_q <= '0;
      ref_gap_q <= '0;
      last_self_q <= 1'b0;
    end else begin
      // saturates so a long self refresh cannot wrap the count
      if (ras_n_q) begin
        ras_lo_cnt_q <= '0;
      end else if (ras_lo_cnt_q != '1) begin
        ras_lo_cnt_q <= ras_lo_cnt_q + 1'b1;
      end
      ras_hi_cnt_q <= ras_n_q ? ras_hi_cnt_q + 1'b1 : '0;
      if (ref_clr || self_refresh_active) begin
        ref_gap_q <= '0;
      end else if (ref_gap_q != '1) begin
        ref_gap_q <= ref_gap_q + 1'b1;
      end
      // taken while ras is low: self_q already clears on the exit edge
      if (!ras_n_q) begin
        last_self_q <= self_q;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence cbr_fall_s;
    $fell(ras_n_q) && !upper_byte_column_strobe_n_n_q && !lower_byte_column_strobe_n_n_q;
  endsequence
  sequence self_exit_s;
    $rose(ras_n_q) && last_self_q;
  endsequence

  cbr_setup_a: assert property (cbr_fall_s |-> !$past(upper_byte_column_strobe_n_n_q)) // see [R5]
    else $error("cas did not lead ras in refresh");
  cbr_hold_a: assert property (cbr_fall_s |=> !upper_byte_column_strobe_n_n_q && !lower_byte_column_strobe_n_n_q) // see [R5]
    else $error("cas released too soon after ras fell");
  pre_cas_a: assert property ($fell(upper_byte_column_strobe_n_n_q) && ras_n_q |-> // see [R6]
      ras_hi_cnt_q >= (TMR_W+1)'(RPC_CYC))
    else $error("cas fell too soon after precharge");
  self_hold_a: assert property (self_exit_s |-> // see [R7]
      $past(ras_lo_cnt_q) >= (TMR_W+1)'(RASS_CYC_P))
    else $error("self refresh pulse too short");
  self_pre_a: assert property ($fell(ras_n_q) && last_self_q |-> // see [R8]
      ras_hi_cnt_q >= (TMR_W+1)'(RPS_CYC))
    else $error("self refresh exit precharge too short");
  self_cas_a: assert property (self_exit_s |-> upper_byte_column_strobe_n_n_q && lower_byte_column_strobe_n_n_q) // see [R9]
    else $error("cas still low after self refresh exit");
  variant_a: assert property (!LOW_POWER |-> !self_refresh_active) // see [R10]
    else $error("self refresh on standard variant");
  read_float_a: assert property ($rose(upper_byte_column_strobe_n_n_q) && !write_q |-> // see [R2]
      oe_n_q && dq_oe_n_q)
    else $error("output enable held past read end");
  cbr_idle_a: assert property (cbr_fall_s |-> // see [R18]
      we_n_q && oe_n_q && dq_oe_n_q)
    else $error("bus active during refresh");
  byte_lane_a: assert property ($fell(upper_byte_column_strobe_n_n_q) && !ras_n_q |-> be_q[1]) // see [R13]
    else $error("upper strobe without its byte enable");
  ref_rate_a: assert property (ref_gap_q <= // see [R17]
      (TMR_W+1)'(2 * REF_CYC_P + RD_CYC + RP_CYC + RCD_CYC))
    else $error("refresh overdue");
endmodule
`default_nettype wire

// *** rtl/edrc_pkg.sv ***
package edrc_pkg;
  localparam int CLK_KHZ = 10_000;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int TMR_W = 11;
  localparam int SYNC_DEPTH = 3;
  localparam int T_CSR_NS = 5;
  localparam int T_CHR_NS = 10;
  localparam int T_RPC_NS = 5;
  localparam int T_RASS_US = 100;
  localparam int T_RPS_NS = 130;
  localparam int T_RP_NS = 50;
  localparam int T_RAS_NS = 70;
  localparam int T_RCD_NS = 14;
  localparam int T_CP_NS = 10;
  localparam int T_CAS_NS = 12;
  localparam int T_RAC_NS = 70;
  localparam int T_REF_MS = 16;
  localparam int REF_ROWS = 1024;

  // least times round up, never below one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * CLK_KHZ + 999_999) / 1_000_000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CSR_CYC = cyc_min(T_CSR_NS);
  localparam int CHR_CYC = cyc_min(T_CHR_NS);
  localparam int RPC_CYC = cyc_min(T_RPC_NS);
  localparam int RPS_CYC = cyc_min(T_RPS_NS);
  localparam int RP_CYC = cyc_min(T_RP_NS);
  localparam int RAS_CYC = cyc_min(T_RAS_NS);
  localparam int RCD_CYC = cyc_min(T_RCD_NS);
  localparam int CP_CYC = cyc_min(T_CP_NS);
  localparam int CAS_CYC = cyc_min(T_CAS_NS);
  localparam int RD_CYC = cyc_min(T_RAC_NS) + SYNC_DEPTH;
  localparam int RASS_CYC = (T_RASS_US * CLK_KHZ + 999) / 1000;
  // longest refresh spacing rounds down
  localparam int REF_CYC = (T_REF_MS * CLK_KHZ) / REF_ROWS;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ROW = 3'b001,
    S_COL = 3'b010,
    S_CEND = 3'b011,
    S_PRE = 3'b100,
    S_CBR_SET = 3'b101,
    S_CBR_HOLD = 3'b110
  } edrc_state_t;
endpackage

// *** rtl/edrc_tmr_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface edrc_tmr_if #(parameter int W = 11);
  logic load;
  logic [W-1:0] value;
  logic expired;
  modport ctl (output load, output value, input expired);
  modport tmr (input load, input value, output expired);
endinterface
`default_nettype wire

// *** rtl/edrc_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module edrc_timer #(
  parameter int W = 11
) (
  input wire logic clk,
  input wire logic srst,
  edrc_tmr_if.tmr t
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (t.load) begin
      count_d = t.value;
    end else if (count_q != '0) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign t.expired = (count_q == '0);
endmodule
`default_nettype wire

// *** test/edrc_dram_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// behavioural memory part; pins sampled on the falling clock edge,
// away from the controller's launch edge
module edrc_dram_model #(
  parameter bit LOW_POWER = 1'b1,
  parameter int RASS_P = 20
) (
  input wire logic clk,
  input wire logic row_strobe_n,
  input wire logic upper_byte_column_strobe_n,
  input wire logic lower_byte_column_strobe_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic [9:0] mem_addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe_n,
  output logic [15:0] dq_in,
  output int ref_cnt,
  output int self_cnt
);
  import edrc_pkg::*;
  logic [15:0] mem [logic [19:0]];
  logic [15:0] last, w;
  logic [9:0] row, col, ref_row;
  logic [1:0] cas_n, cas_p, rd_lane;
  logic ras_p, in_ref;
  int low_cnt;
  assign cas_n = {upper_byte_column_strobe_n, lower_byte_column_strobe_n};
  initial begin
    {ref_cnt, self_cnt, low_cnt} = '0;
    {row, col, ref_row, last, dq_in} = '0;
    {ras_p, cas_p, rd_lane, in_ref} = 6'h38;
  end
  always @(negedge clk) begin
    if (ras_p && !row_strobe_n) begin
      // any column strobe low at row fall: refresh, address ignored
      in_ref = (cas_n != 2'h3);
      low_cnt = 0;
      if (in_ref) ref_row = ref_row + 10'h001;
      else row = mem_addr;
    end
    if (!row_strobe_n) low_cnt++;
    if (!ras_p && row_strobe_n && in_ref) begin
      if (LOW_POWER && low_cnt >= RASS_P) self_cnt++;
      else ref_cnt++;
      in_ref = 1'b0;
    end
    for (int b = 0; b < 2; b++) begin
      if (!row_strobe_n && !in_ref && cas_p[b] && !cas_n[b]) begin
        col = mem_addr;
        rd_lane[b] = write_enable_n;
        if (!write_enable_n && !dq_oe_n) begin
          w = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
          w[8*b+:8] = dq_out[8*b+:8];
          mem[{row, col}] = w;
        end
      end
      if ((row_strobe_n && cas_n[b]) || output_enable_n || !write_enable_n)
        rd_lane[b] = 1'b0;
      // a floating lane shows the inverse of its last driven value
      if (rd_lane[b] && !in_ref) begin
        w = mem[{row, col}];
        last[8*b+:8] = w[8*b+:8];
        dq_in[8*b+:8] = last[8*b+:8];
      end else begin
        dq_in[8*b+:8] = ~last[8*b+:8];
      end
    end
    ras_p = row_strobe_n;
    cas_p = cas_n;
  end
endmodule
`default_nettype wire

// *** test/edrc_ctrl_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module edrc_ctrl_tb_top;
  import edrc_pkg::*;
  // shortened counts keep the run brief
  localparam int REF_P = 60;
  localparam int RASS_P = 20;
  logic clk, srst, req_valid, req_ready, req_write, rsp_valid;
  logic self_refresh_req, self_refresh_active, row_strobe_n, write_enable_n;
  logic upper_byte_column_strobe_n, lower_byte_column_strobe_n;
  logic output_enable_n, dq_oe_n, ras_p, uc_p, lc_p, in_r, sr, sr_last;
  logic [1:0] req_be;
  logic [19:0] req_addr;
  logic [15:0] req_wdata, rsp_rdata, dq_out, dq_in;
  logic [9:0] mem_addr;
  logic [31:0] e;
  logic [31:0] exp_q[$];
  logic [19:0] addr_t[8];
  logic [15:0] shadow[8];
  int error_cnt, checks, seed, ref_cnt, self_cnt, hi, lo, gap, i, s0;
  edrc_ctrl #(.REF_CYC_P(REF_P), .RASS_CYC_P(RASS_P)) u_dut (.clk, .srst,
    .req_valid, .req_ready, .req_write, .req_be, .req_addr, .req_wdata,
    .rsp_valid, .rsp_rdata, .self_refresh_req, .self_refresh_active,
    .row_strobe_n, .upper_byte_column_strobe_n, .lower_byte_column_strobe_n,
    .write_enable_n, .output_enable_n, .mem_addr, .dq_out, .dq_oe_n, .dq_in);
  edrc_dram_model #(.RASS_P(RASS_P)) u_mem (.clk, .row_strobe_n,
    .upper_byte_column_strobe_n, .lower_byte_column_strobe_n,
    .write_enable_n, .output_enable_n, .mem_addr, .dq_out, .dq_oe_n,
    .dq_in, .ref_cnt, .self_cnt);
  // standard variant watches the same requests and must never self refresh
  logic std_active;
  edrc_ctrl #(.LOW_POWER(1'b0), .REF_CYC_P(REF_P)) u_std (.clk, .srst,
    .req_valid, .req_ready(), .req_write, .req_be, .req_addr, .req_wdata,
    .rsp_valid(), .rsp_rdata(), .self_refresh_req,
    .self_refresh_active(std_active), .row_strobe_n(),
    .upper_byte_column_strobe_n(), .lower_byte_column_strobe_n(),
    .write_enable_n(), .output_enable_n(), .mem_addr(), .dq_out(),
    .dq_oe_n(), .dq_in);
  task automatic close_out();
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic req(input logic w, input int k, input logic [1:0] be);
    int n;
    logic [15:0] m;
    n = 0;
    m = {{8{be[1]}}, {8{be[0]}}};
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_be = be;
    req_addr = addr_t[k];
    req_wdata = 16'($random(seed));
    #1;
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      #1;
      n++;
    end
    chk(n < 400, "request never taken");
    if (n >= 400) close_out();
    if (w) shadow[k] = (shadow[k] & ~m) | (req_wdata & m);
    else exp_q.push_back({m, shadow[k]});
    @(posedge clk);
  endtask
  // hold the request for hold cycles once the pulse is running, then drop it
  task automatic selfr(input int hold);
    int n;
    n = 0;
    s0 = self_cnt;
    @(negedge clk);
    req_valid = 1'b0;
    self_refresh_req = 1'b1;
    while (self_refresh_active !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk(std_active === 1'b0, "standard part in self refresh");
    repeat (hold) @(negedge clk);
    self_refresh_req = 1'b0;
    while (self_refresh_active !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    chk(n < 1000 && self_cnt == s0 + 1, "self refresh not done");
  endtask
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 32'hffff_xxxx;
      chk((rsp_rdata & e[31:16]) === (e[15:0] & e[31:16]),
        "read data");
    end
  end
  // pin monitor for the refresh sequences
  always @(negedge clk) begin
    if (srst) begin
      {hi, lo, gap, in_r, sr, sr_last} = '0;
    end else begin
      if (in_r && self_refresh_active === 1'b1) sr = 1'b1;
      if (ras_p && !row_strobe_n) begin
        if (sr_last) chk(hi >= RPS_CYC, "exit precharge");
        sr_last = 1'b0;
        if (!(upper_byte_column_strobe_n && lower_byte_column_strobe_n)) begin
          chk(uc_p === 1'b0 && lc_p === 1'b0, "cas setup");
          chk(gap <= REF_P + 20, "refresh late");
          gap = 0;
          in_r = 1'b1;
        end
      end
      if (in_r && ((upper_byte_column_strobe_n && !uc_p) ||
          (lower_byte_column_strobe_n && !lc_p)))
        chk(lo >= CHR_CYC, "cas hold");
      if (row_strobe_n && ((!upper_byte_column_strobe_n && uc_p) ||
          (!lower_byte_column_strobe_n && lc_p)))
        chk(hi >= RPC_CYC, "precharge cas hold");
      if (!ras_p && row_strobe_n && in_r) begin
        if (sr) begin
          chk(lo >= RASS_P, "self pulse short");
          chk(uc_p === 1'b0 && lc_p === 1'b0, "cas early");
          gap = 0;
        end
        sr_last = sr;
        {sr, in_r} = 2'h0;
      end
      hi = row_strobe_n ? hi + 1 : 0;
      lo = row_strobe_n ? 0 : lo + 1;
      gap++;
    end
    {ras_p, uc_p, lc_p} = {row_strobe_n, upper_byte_column_strobe_n,
      lower_byte_column_strobe_n};
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {srst, seed, error_cnt, checks} = {1'b1, 32'h384f, 64'h0};
    {req_valid, req_write, req_be, req_addr, req_wdata} = '0;
    self_refresh_req = 1'b0;
    s0 = $random(seed);
    // low column bits carry the slot index so no two slots alias
    for (i = 0; i < 8; i++)
      addr_t[i] = {s0[i/4*10+:10], 7'($random(seed)), 3'(i)};
    repeat (4) @(negedge clk);
    srst = 1'b0;
    for (i = 0; i < 8; i++) req(1'b1, i, 2'h3);
    for (i = 0; i < 60; i++)
      req(1'($random(seed)), $unsigned($random(seed)) % 8,
        2'($unsigned($random(seed)) % 3 + 1));
    for (i = 0; i < 8; i++) req(1'b0, i, 2'h3);
    selfr(30);
    selfr(0);
    for (i = 0; i < 8; i++) req(1'b0, i, 2'h3);
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 100 && exp_q.size() > 0; i++) @(negedge clk);
    chk(exp_q.size() == 0, "reads missing");
    chk(ref_cnt > 0, "no refresh seen");
    close_out();
  end
endmodule
`default_nettype wire
